// >>> inc/exec_state_params.svh
`ifndef EXEC_STATE_PARAMS_SVH
`define EXEC_STATE_PARAMS_SVH

// States per cycle on on-chip memory
`define STATES_MEM          3'h2
// States per internal operation
`define STATES_INTERNAL     3'h1
// Peripheral access states, fast and slow module
`define STATES_PERIPH_FAST  3'h2
`define STATES_PERIPH_SLOW  3'h3

// Instruction class codes on op_class_i
`define OP_ADD_B_IMM        5'h00
`define OP_ADD_B_REG        5'h01
`define OP_ADD_W_IMM        5'h02
`define OP_ADD_W_REG        5'h03
`define OP_ADD_L_IMM        5'h04
`define OP_ADD_L_REG        5'h05
`define OP_ADD_CONST_ADDR   5'h06
`define OP_ADD_WITH_CARRY   5'h07
`define OP_AND_B_IMM        5'h08
`define OP_AND_B_REG        5'h09
`define OP_AND_W_IMM        5'h0a
`define OP_AND_W_REG        5'h0b
`define OP_AND_L_IMM        5'h0c
`define OP_AND_L_REG        5'h0d
`define OP_AND_CCR          5'h0e
`define OP_BIT_AND_REG      5'h0f
`define OP_BIT_AND_MEM      5'h10
`define OP_BRANCH_D8        5'h11
`define OP_BIT_SET_MEM      5'h12
`define OP_CALL_INDIRECT    5'h13

`endif

// >>> inc/exec_state_pkg.sv
package exec_state_pkg;

  // Bus/internal cycle kinds, one-hot
  typedef enum logic [5:0] {
    CYC_FETCH    = 6'h01,
    CYC_BRANCH   = 6'h02,
    CYC_STACK    = 6'h04,
    CYC_BYTE     = 6'h08,
    CYC_WORD     = 6'h10,
    CYC_INTERNAL = 6'h20
  } cycle_kind_t;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h1,
    SEQ_RUN  = 3'h2,
    SEQ_DONE = 3'h4
  } seq_state_t;

  typedef logic [2:0] count_t;

endpackage : exec_state_pkg

// >>> verilog/cpu_execution_state_counter.sv
// Notes on behaviour
// - Total states is sum of count times weight
// - On-chip memory cycles take two states
// - Peripheral data access takes two or three
// - Internal operation takes one state
// - Add immediate fetches by width, register one
// - Bit-AND memory: two fetches, one byte read
// - Short branches: two fetches, no internal
// - Bit-set memory: two fetches, read then write
// - Indirect call: two fetch, vector, stack
`include "exec_state_params.svh"

module cpu_execution_state_counter
  import exec_state_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  input  wire logic       start_i,
  input  wire logic [4:0] op_class_i,
  input  wire logic       data_periph_i,
  input  wire logic       periph_slow_i,
  output logic            busy_o,
  output logic            done_o,
  output logic [5:0]      cycle_kind_o,
  output logic            cycle_start_o,
  output logic            data_write_o,
  output logic [7:0]      total_states_o
);

  // ==========================================================
  // Decode of cycle counts
  // ==========================================================
  count_t n_fetch, n_branch, n_stack, n_byte, n_word, n_internal;

  always_comb begin
    n_fetch    = 3'h1;
    n_branch   = 3'h0;
    n_stack    = 3'h0;
    n_byte     = 3'h0;
    n_word     = 3'h0;
    n_internal = 3'h0;
    case (op_class_i)
      `OP_ADD_W_IMM, `OP_AND_W_IMM: n_fetch = 3'h2;
      `OP_ADD_L_IMM, `OP_AND_L_IMM: n_fetch = 3'h3;
      `OP_AND_L_REG: n_fetch = 3'h2;
      `OP_ADD_CONST_ADDR, `OP_ADD_WITH_CARRY, `OP_AND_CCR:
        n_fetch = 3'h1;
      `OP_BIT_AND_MEM: begin
        n_fetch = 3'h2;
        n_byte  = 3'h1;
      end
      `OP_BRANCH_D8: n_fetch = 3'h2;
      `OP_BIT_SET_MEM: begin
        n_fetch = 3'h2;
        n_byte  = 3'h2;
      end
      `OP_CALL_INDIRECT: begin
        n_fetch  = 3'h2;
        n_branch = 3'h1;
        n_stack  = 3'h1;
      end
      default: n_fetch = 3'h1;
    endcase
  end

  // ==========================================================
  // Sequencer
  // ==========================================================
  seq_state_t state;
  count_t     rem_fetch, rem_branch, rem_stack;
  count_t     rem_byte, rem_word, rem_internal;
  count_t     state_left;
  logic       periph;
  logic       slow;
  logic       byte_seen;
  logic       last_state;
  logic       any_left;

  assign last_state = (state == SEQ_RUN) && (state_left == 3'h1);
  assign any_left   = |{rem_fetch, rem_branch, rem_stack,
                        rem_byte, rem_word, rem_internal};

  count_t data_weight;
  assign data_weight = !periph ? `STATES_MEM :
                       (slow ? `STATES_PERIPH_SLOW
                             : `STATES_PERIPH_FAST);

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state <= SEQ_IDLE;
    end else begin
      case (state)
        SEQ_IDLE: if (start_i) state <= SEQ_RUN;
        SEQ_RUN:  if (last_state && !any_left) state <= SEQ_DONE;
        SEQ_DONE: state <= SEQ_IDLE;
        default:  state <= SEQ_IDLE;
      endcase
    end
  end

  // Picks next cycle in fixed order; one at a time, never overlapped
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rem_fetch    <= 3'h0;
      rem_branch   <= 3'h0;
      rem_stack    <= 3'h0;
      rem_byte     <= 3'h0;
      rem_word     <= 3'h0;
      rem_internal <= 3'h0;
      state_left   <= 3'h0;
      cycle_kind_o <= 6'h00;
      periph       <= 1'b0;
      slow         <= 1'b0;
      byte_seen    <= 1'b0;
      data_write_o <= 1'b0;
    end else if (state == SEQ_IDLE && start_i) begin
      // First cycle is always a fetch; counts latched at start
      rem_fetch    <= n_fetch - 3'h1;
      rem_branch   <= n_branch;
      rem_stack    <= n_stack;
      rem_byte     <= n_byte;
      rem_word     <= n_word;
      rem_internal <= n_internal;
      periph       <= data_periph_i;
      slow         <= periph_slow_i;
      byte_seen    <= 1'b0;
      data_write_o <= 1'b0;
      cycle_kind_o <= CYC_FETCH;
      state_left   <= `STATES_MEM;
    end else if (state == SEQ_RUN) begin
      if (!last_state) begin
        state_left <= state_left - 3'h1;
      end else if (rem_fetch != 3'h0) begin
        rem_fetch    <= rem_fetch - 3'h1;
        cycle_kind_o <= CYC_FETCH;
        state_left   <= `STATES_MEM;
      end else if (rem_branch != 3'h0) begin
        rem_branch   <= rem_branch - 3'h1;
        cycle_kind_o <= CYC_BRANCH;
        state_left   <= `STATES_MEM;
      end else if (rem_stack != 3'h0) begin
        rem_stack    <= rem_stack - 3'h1;
        cycle_kind_o <= CYC_STACK;
        state_left   <= `STATES_MEM;
      end else if (rem_byte != 3'h0) begin
        rem_byte     <= rem_byte - 3'h1;
        cycle_kind_o <= CYC_BYTE;
        data_write_o <= byte_seen;
        byte_seen    <= 1'b1;
        state_left   <= data_weight;
      end else if (rem_word != 3'h0) begin
        rem_word     <= rem_word - 3'h1;
        cycle_kind_o <= CYC_WORD;
        data_write_o <= 1'b0;
        state_left   <= data_weight;
      end else if (rem_internal != 3'h0) begin
        rem_internal <= rem_internal - 3'h1;
        cycle_kind_o <= CYC_INTERNAL;
        data_write_o <= 1'b0;
        state_left   <= `STATES_INTERNAL;
      end else begin
        cycle_kind_o <= 6'h00;
        data_write_o <= 1'b0;
        state_left   <= 3'h0;
      end
    end else begin
      cycle_kind_o <= 6'h00;
      data_write_o <= 1'b0;
    end
  end

  // Cycle start marks the first state of each issued cycle
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cycle_start_o <= 1'b0;
    end else begin
      cycle_start_o <= (state == SEQ_IDLE && start_i) ||
                       (last_state && any_left);
    end
  end

  // ==========================================================
  // State total, one per clock while running
  // ==========================================================
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      total_states_o <= 8'h00;
    end else if (state == SEQ_IDLE && start_i) begin
      total_states_o <= 8'h00;
    end else if (state == SEQ_RUN) begin
      total_states_o <= total_states_o + 8'h01;
    end
  end

  assign busy_o = (state != SEQ_IDLE);
  assign done_o = (state == SEQ_DONE);

  // ==========================================================
  // Checks
  // ==========================================================
  sequence s_start_set;
    state == SEQ_IDLE && start_i && op_class_i == `OP_BIT_SET_MEM
      && !data_periph_i;
  endsequence

  sequence s_start_call;
    state == SEQ_IDLE && start_i && op_class_i == `OP_CALL_INDIRECT;
  endsequence

  a_bitset_total_eight: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    s_start_set |-> ##9 (done_o && total_states_o == 8'h08))
    else $error("bit set on memory did not total eight states");

  a_bitset_writeback: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    s_start_set |-> ##5 (cycle_kind_o == CYC_BYTE && !data_write_o)
      ##2 (cycle_kind_o == CYC_BYTE && data_write_o))
    else $error("bit set write-back not after read");

  a_call_total_eight: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    s_start_call |-> ##5 cycle_kind_o == CYC_BRANCH
      ##2 cycle_kind_o == CYC_STACK ##2 done_o)
    else $error("indirect call cycle order wrong");

  a_branch_two_fetch: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (state == SEQ_IDLE && start_i && op_class_i == `OP_BRANCH_D8)
      |-> ##5 (done_o && total_states_o == 8'h04))
    else $error("short branch not four states");

  a_fetch_two_states: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (cycle_start_o && cycle_kind_o == CYC_FETCH)
      |-> ##1 (cycle_kind_o == CYC_FETCH && !cycle_start_o)
      ##1 (cycle_start_o || done_o))
    else $error("fetch cycle not two states");

  a_periph_slow_three: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (cycle_start_o && cycle_kind_o == CYC_BYTE && periph && slow)
      |=> !cycle_start_o [*2] ##1 (cycle_start_o || done_o))
    else $error("slow peripheral access not three states");

  a_add_long_imm: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (state == SEQ_IDLE && start_i && op_class_i == `OP_ADD_L_IMM)
      |-> ##7 (done_o && total_states_o == 8'h06))
    else $error("long add immediate not three fetches");

  a_and_long_reg: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (state == SEQ_IDLE && start_i && op_class_i == `OP_AND_L_REG)
      |-> ##5 done_o)
    else $error("long register and not two fetches");

  a_single_fetch: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (state == SEQ_IDLE && start_i && op_class_i == `OP_ADD_WITH_CARRY)
      |-> ##3 (done_o && total_states_o == 8'h02))
    else $error("add with carry not one fetch");

  a_bitand_read: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (state == SEQ_IDLE && start_i && op_class_i == `OP_BIT_AND_MEM
      && !data_periph_i)
      |-> ##5 (cycle_kind_o == CYC_BYTE && !data_write_o) ##2 done_o)
    else $error("bit and memory read sequence wrong");

endmodule : cpu_execution_state_counter

// >>> bench/mem_bus_model.sv
// ===========================================================
// Bus target: tallies cycles issued by the sequencer
// ===========================================================
module mem_bus_model (
  input  wire logic        core_clk_i,
  input  wire logic        clear_i,
  input  wire logic [5:0]  cycle_kind_i,
  input  wire logic        cycle_start_i,
  input  wire logic        data_write_i,
  output logic      [23:0] kind_count_o,
  output logic      [3:0]  write_count_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // One nibble per kind, bit order of the one-hot code
  always_ff @(posedge core_clk_i) begin
    if (clear_i) begin
      kind_count_o  <= '0;
      write_count_o <= '0;
    end else if (cycle_start_i) begin
      for (int b = 0; b < 6; b++) begin
        if (cycle_kind_i[b]) begin
          kind_count_o[b*4 +: 4] <= kind_count_o[b*4 +: 4] + 4'h1;
        end
      end
      if (data_write_i) begin
        write_count_o <= write_count_o + 4'h1;
      end
    end
  end
endmodule : mem_bus_model

// >>> bench/tb_cpu_execution_state_counter.sv
`include "exec_state_params.svh"
module tb_cpu_execution_state_counter
  import exec_state_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk_i, reset_i, start_i, data_periph_i, periph_slow_i;
  logic [4:0]  op_class_i;
  logic        busy_o, done_o, cycle_start_o, data_write_o;
  logic [5:0]  cycle_kind_o;
  logic [7:0]  total_states_o;
  logic [23:0] kind_count;
  logic [3:0]  write_count;
  int          miscompares, num_checks, cycles;

  cpu_execution_state_counter i_dut (.core_clk_i(core_clk_i),
    .reset_i(reset_i), .start_i(start_i), .op_class_i(op_class_i),
    .data_periph_i(data_periph_i), .periph_slow_i(periph_slow_i),
    .busy_o(busy_o), .done_o(done_o), .cycle_kind_o(cycle_kind_o),
    .cycle_start_o(cycle_start_o), .data_write_o(data_write_o),
    .total_states_o(total_states_o));
  // Clear only on the edge that really takes a request
  mem_bus_model i_bus (.core_clk_i(core_clk_i),
    .clear_i(start_i & ~busy_o), .cycle_kind_i(cycle_kind_o),
    .cycle_start_i(cycle_start_o), .data_write_i(data_write_o),
    .kind_count_o(kind_count), .write_count_o(write_count));

  // ===========================================================
  // Reporting
  // ===========================================================
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  // ===========================================================
  // One instruction; start held one cycle extra to be refused
  // ===========================================================
  // Counts packed as nibbles: write, byte, stack, branch, fetch
  task automatic run_op(input logic [4:0]  op,
                        input logic        per,
                        input logic        slow,
                        input logic [19:0] cnt);
    logic [7:0] s;
    logic [7:0] n;
    logic [7:0] w;
    w = per ? (slow ? 8'(`STATES_PERIPH_SLOW) : 8'(`STATES_PERIPH_FAST))
            : 8'(`STATES_MEM);
    s = 8'(cnt[3:0] + cnt[7:4] + cnt[11:8]) * 8'(`STATES_MEM);
    s = s + 8'(cnt[15:12]) * w;
    op_class_i    = op;
    data_periph_i = per;
    periph_slow_i = slow;
    start_i       = 1'b1;
    n             = 8'h00;
    while (done_o !== 1'b1 && n < 8'h28) begin
      @(negedge core_clk_i);
      n = n + 8'h01;
      if (n == 8'h01) begin
        check(24'(busy_o), 24'h000001);
      end
      if (n == 8'h02) start_i = 1'b0;
    end
    check(24'(n), 24'(s + 8'h01));
    check(24'(total_states_o), 24'(s));
    check(kind_count, {8'h00, cnt[15:0]});
    check(24'(write_count), 24'(cnt[19:16]));
    @(negedge core_clk_i);
    check(24'(busy_o), 24'h000000);
  endtask : run_op

  // ===========================================================
  // Scenarios
  // ===========================================================
  task automatic t_add_and();
    logic [3:0] f [15];
    f = '{4'h1, 4'h1, 4'h2, 4'h1, 4'h3, 4'h1, 4'h1, 4'h1,
          4'h1, 4'h1, 4'h2, 4'h1, 4'h3, 4'h2, 4'h1};
    for (int i = 0; i < 15; i++) begin
      run_op(5'(i), 1'b0, 1'b0, {16'h0000, f[i]});
    end
    // Codes outside the covered set run as a single fetch
    run_op(5'h1f, 1'b0, 1'b0, 20'h00001);
  endtask : t_add_and

  task automatic t_bit_ops();
    run_op(`OP_BIT_AND_REG, 1'b1, 1'b1, 20'h00001);
    run_op(`OP_BIT_AND_MEM, 1'b1, 1'b1, 20'h01002);
    run_op(`OP_BIT_SET_MEM, 1'b0, 1'b1, 20'h12002);
    run_op(`OP_BIT_SET_MEM, 1'b1, 1'b0, 20'h12002);
    run_op(`OP_BIT_SET_MEM, 1'b1, 1'b1, 20'h12002);
  endtask : t_bit_ops

  task automatic t_branch_call();
    run_op(`OP_BRANCH_D8, 1'b1, 1'b1, 20'h00002);
    run_op(`OP_CALL_INDIRECT, 1'b1, 1'b1, 20'h00112);
  endtask : t_branch_call

  // Abort mid-instruction, then the next one must run clean
  task automatic t_mid_reset();
    op_class_i = `OP_BIT_SET_MEM;
    start_i    = 1'b1;
    repeat (4) @(negedge core_clk_i);
    start_i = 1'b0;
    reset_i = 1'b1;
    @(negedge core_clk_i);
    check(24'({busy_o, done_o, cycle_start_o, data_write_o,
               cycle_kind_o, total_states_o}), 24'h000000);
    reset_i = 1'b0;
    @(negedge core_clk_i);
    check(24'({busy_o, cycle_start_o, total_states_o}), 24'h000000);
    run_op(`OP_CALL_INDIRECT, 1'b0, 1'b0, 20'h00112);
  endtask : t_mid_reset

  // ===========================================================
  // Clock, watchdog and main sequence
  // ===========================================================
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // About 170 cycles of work; a hang ends at cycle 5000, well above this
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      print_verdict();
    end
  end

  initial begin
    reset_i       = 1'b1;
    start_i       = 1'b0;
    op_class_i    = 5'h00;
    data_periph_i = 1'b0;
    periph_slow_i = 1'b0;
    // Rising edges counted, so the start-up step to 0 is no cycle
    repeat (10) @(posedge core_clk_i);
    @(negedge core_clk_i);
    reset_i = 1'b0;
    @(negedge core_clk_i);
    t_add_and();
    t_bit_ops();
    t_branch_call();
    t_mid_reset();
    print_verdict();
  end
endmodule : tb_cpu_execution_state_counter
